// ===== rtl/ils_pkg.sv
// Constants shared by the interrupt level setup block.
// Assumes one 40 MHz core clock and word-aligned AHB-Lite access.
package ils_pkg;
  // ==========================================================
  // Geometry
  localparam int ILS_NUM_REGS     = 8;
  localparam int ILS_NUM_SRC      = 16;
  localparam int ILS_LV_W         = 3;
  localparam int ILS_REG_W        = 16;
  localparam int ILS_IDX_W        = 3;
  localparam int ILS_SRC_W        = 4;
  localparam int ILS_FIELD_LO_POS = 0;
  localparam int ILS_FIELD_HI_POS = 8;
  // ==========================================================
  // Register map: index as printed, byte address is four times it
  localparam logic [29:0] ILS_LV_INDEX [ILS_NUM_REGS] = '{
    30'h4080, 30'h4082, 30'h4084, 30'h4086,
    30'h4088, 30'h408a, 30'h408c, 30'h408e};
  localparam logic [15:0] ILS_LV_MASK  = 16'h0707;
  localparam logic [15:0] ILS_LV_RESET = 16'h0000;
  // ==========================================================
  // Bus encodings
  localparam int   ILS_HTRANS_ACT_BIT = 1;
  localparam logic ILS_HRESP_OKAY     = 1'b0;
endpackage : ils_pkg

// ===== rtl/ils_reg_if.sv
// Register access carrier between bus slave and level bank.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface ils_reg_if;
  import ils_pkg::*;
  logic                 wr_en;
  logic [ILS_IDX_W-1:0] wr_idx;
  logic [ILS_REG_W-1:0] wr_data;
  logic                 rd_en;
  logic                 rd_hit;
  logic [ILS_IDX_W-1:0] rd_idx;
  logic [ILS_REG_W-1:0] rd_data;
  // Bus side drives requests
  modport bus  (output wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx,
                input  rd_data);
  // Bank side answers
  modport bank (input  wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx,
                output rd_data);
endinterface : ils_reg_if

// ===== rtl/ils_level_bank.sv
// Eight level registers with a registered read port.
// Assumes writes and reads arrive from the bus slave on core_clk.
`timescale 1ns/1ps
module ils_level_bank import ils_pkg::*; (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  input  wire logic                                level_clear,
  // Register port
  ils_reg_if.bank                                  regs,
  // Stored words
  output logic [ILS_NUM_REGS-1:0][ILS_REG_W-1:0]  words
);
  // ==========================================================
  // Storage
  logic [ILS_REG_W-1:0] word_r [ILS_NUM_REGS];
  logic [ILS_REG_W-1:0] fwd_word;
  logic [ILS_REG_W-1:0] rd_nxt;

  // One word per register, only level bits are kept; clear beats a write
  for (genvar k = 0; k < ILS_NUM_REGS; k++) begin : g_word
    always_ff @(posedge core_clk) begin
      if (!rst_n || level_clear) begin
        word_r[k] <= ILS_LV_RESET;
      end else if (regs.wr_en && regs.wr_idx == ILS_IDX_W'(k)) begin
        word_r[k] <= regs.wr_data & ILS_LV_MASK;
      end
    end
    assign words[k] = word_r[k];
  end

  // ==========================================================
  // Read port, forwards a write landing in the same cycle
  assign fwd_word = (regs.wr_en && regs.wr_idx == regs.rd_idx && !level_clear) ?
                    (regs.wr_data & ILS_LV_MASK) : word_r[regs.rd_idx];
  assign rd_nxt   = regs.rd_hit ? fwd_word : '0;

  // Read data register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regs.rd_data <= '0;
    end else if (regs.rd_en) begin
      regs.rd_data <= rd_nxt;
    end
  end
endmodule : ils_level_bank

// ===== rtl/ils_ahb_slave.sv
// AHB-Lite slave front end for the level registers.
// Assumes single word transfers; answers with no wait state.
`timescale 1ns/1ps
module ils_ahb_slave import ils_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Address phase
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  // Data phase
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  // Register port
  ils_reg_if.bus           regs
);
  // ==========================================================
  // Address decode
  logic [ILS_NUM_REGS-1:0] hit_vec;
  logic [ILS_IDX_W-1:0]    hit_idx;
  logic                    xfer;
  logic                    wr_pend_r;
  logic [ILS_IDX_W-1:0]    wr_idx_r;

  // Priority-free encoder of the one-hot hit
  function automatic logic [ILS_IDX_W-1:0] ils_enc(input logic [ILS_NUM_REGS-1:0] v);
    logic [ILS_IDX_W-1:0] r;
    r = '0;
    for (int i = 0; i < ILS_NUM_REGS; i++) begin
      if (v[i]) begin
        r = r | ILS_IDX_W'(i);
      end
    end
    return r;
  endfunction : ils_enc

  // One comparator per register
  for (genvar k = 0; k < ILS_NUM_REGS; k++) begin : g_hit
    assign hit_vec[k] = (haddr == {ILS_LV_INDEX[k], 2'b00});
  end

  // Transfer qualification and read request
  assign xfer        = hsel & htrans[ILS_HTRANS_ACT_BIT] & hready;
  assign hit_idx     = ils_enc(hit_vec);
  assign regs.rd_en  = xfer & ~hwrite;
  assign regs.rd_hit = |hit_vec;
  assign regs.rd_idx = hit_idx;

  // Write address held into the data phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= '0;
    end else if (hready) begin
      wr_pend_r <= xfer & hwrite & (|hit_vec);
      wr_idx_r  <= hit_idx;
    end
  end

  // Write strobe and fixed answer
  assign regs.wr_en   = wr_pend_r;
  assign regs.wr_idx  = wr_idx_r;
  assign regs.wr_data = hwdata[ILS_REG_W-1:0];
  assign hreadyout    = 1'b1;
  assign hresp        = ILS_HRESP_OKAY;
endmodule : ils_ahb_slave

// ===== rtl/ils_top.sv
// Interrupt level setup: sixteen 3-bit levels over AHB-Lite,
// plus a selector that offers the highest pending level to the CPU.
// Assumes peripheral requests and the reset group come from core_clk logic.
`timescale 1ns/1ps
// Function
// - Register 0x4080 holds supply monitor level low, port level high.
// - Register 0x4082 holds clock generator level low, RTC level high.
// - Register 0x4084 holds timer 0 level low, UART level high.
// - Register 0x4086 holds timer 1 level low, serial 0 level high.
// - Register 0x4088 holds I2C level low, timer 2 level high.
// - Register 0x408a holds timer 3 level low, timer 4 level high.
// - Register 0x408c holds serial 1 level low, LCD level high.
// - Register 0x408e holds R/F converter level low, MR sensor level high.
module ils_top import ils_pkg::*; (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   hard_reset_group_zero,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Peripheral requests
  input  wire logic [ILS_NUM_SRC-1:0] irq_src,
  // CPU request
  output logic                        cpu_irq_req,
  output logic [ILS_LV_W-1:0]         cpu_irq_level,
  output logic [ILS_SRC_W-1:0]        cpu_irq_src
);
  // ==========================================================
  // Register access
  ils_reg_if reg_bus ();
  logic [ILS_NUM_REGS-1:0][ILS_REG_W-1:0] lv_words;
  logic                                   level_clear;

  // Reset group clears every level field
  assign level_clear = hard_reset_group_zero;

  // Bus front end
  ils_ahb_slave u_slave (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (reg_bus.bus)
  );

  // Level storage
  ils_level_bank u_bank (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .level_clear (level_clear),
    .regs        (reg_bus.bank),
    .words       (lv_words)
  );

  // Upper half and unused bits always zero
  assign hrdata = {16'h0000, reg_bus.rd_data};

  // ==========================================================
  // Level fields per source
  logic [ILS_LV_W-1:0] level_supply_monitor;
  logic [ILS_LV_W-1:0] level_port;
  logic [ILS_LV_W-1:0] level_clock_gen;
  logic [ILS_LV_W-1:0] level_rtc;
  logic [ILS_LV_W-1:0] level_timer_ch0;
  logic [ILS_LV_W-1:0] level_uart;
  logic [ILS_LV_W-1:0] level_timer_ch1;
  logic [ILS_LV_W-1:0] level_sync_serial_ch0;
  logic [ILS_LV_W-1:0] level_i2c;
  logic [ILS_LV_W-1:0] level_timer_ch2;
  logic [ILS_LV_W-1:0] level_timer_ch3;
  logic [ILS_LV_W-1:0] level_timer_ch4;
  logic [ILS_LV_W-1:0] level_sync_serial_ch1;
  logic [ILS_LV_W-1:0] level_lcd_driver;
  logic [ILS_LV_W-1:0] level_res_freq_conv;
  logic [ILS_LV_W-1:0] level_mr_sensor;

  // Field placement, low field then high field per word
  assign level_supply_monitor  = lv_words[0][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_port            = lv_words[0][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_clock_gen       = lv_words[1][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_rtc             = lv_words[1][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_timer_ch0       = lv_words[2][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_uart            = lv_words[2][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_timer_ch1       = lv_words[3][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_sync_serial_ch0 = lv_words[3][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_i2c             = lv_words[4][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_timer_ch2       = lv_words[4][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_timer_ch3       = lv_words[5][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_timer_ch4       = lv_words[5][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_sync_serial_ch1 = lv_words[6][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_lcd_driver      = lv_words[6][ILS_FIELD_HI_POS +: ILS_LV_W];
  assign level_res_freq_conv   = lv_words[7][ILS_FIELD_LO_POS +: ILS_LV_W];
  assign level_mr_sensor       = lv_words[7][ILS_FIELD_HI_POS +: ILS_LV_W];

  // Levels ordered by source number
  logic [ILS_NUM_SRC-1:0][ILS_LV_W-1:0] lv_by_src;
  assign lv_by_src = {level_mr_sensor, level_res_freq_conv,
                      level_lcd_driver, level_sync_serial_ch1,
                      level_timer_ch4, level_timer_ch3,
                      level_timer_ch2, level_i2c,
                      level_sync_serial_ch0, level_timer_ch1,
                      level_uart, level_timer_ch0,
                      level_rtc, level_clock_gen,
                      level_port, level_supply_monitor};

  // ==========================================================
  // Request selection
  logic                 best_found;
  logic [ILS_LV_W-1:0]  best_lvl;
  logic [ILS_SRC_W-1:0] best_src;
  logic                 cpu_irq_req_r;
  logic [ILS_LV_W-1:0]  cpu_irq_level_r;
  logic [ILS_SRC_W-1:0] cpu_irq_src_r;

  // Highest level wins, lower source number breaks ties
  always_comb begin
    best_found = 1'b0;
    best_lvl   = '0;
    best_src   = '0;
    for (int i = 0; i < ILS_NUM_SRC; i++) begin
      if (irq_src[i] && (!best_found || lv_by_src[i] > best_lvl)) begin
        best_found = 1'b1;
        best_lvl   = lv_by_src[i];
        best_src   = ILS_SRC_W'(i);
      end
    end
  end

  // Registered request to the CPU
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_irq_req_r   <= 1'b0;
      cpu_irq_level_r <= '0;
      cpu_irq_src_r   <= '0;
    end else begin
      cpu_irq_req_r   <= best_found;
      cpu_irq_level_r <= best_lvl;
      cpu_irq_src_r   <= best_src;
    end
  end

  assign cpu_irq_req   = cpu_irq_req_r;
  assign cpu_irq_level = cpu_irq_level_r;
  assign cpu_irq_src   = cpu_irq_src_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic wr_ok;
  assign wr_ok = reg_bus.wr_en && !hard_reset_group_zero;

  lv0_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h0 |=> level_supply_monitor == $past(reg_bus.wr_data[2:0])
      && level_port == $past(reg_bus.wr_data[10:8]))
    else $error("level register 0 did not take write");
  lv1_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h1 ##1 1'b1 |-> level_clock_gen == $past(reg_bus.wr_data[2:0])
      && level_rtc == $past(reg_bus.wr_data[10:8]))
    else $error("level register 1 did not take write");
  lv2_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h2 |=> {level_uart, level_timer_ch0}
      == {$past(reg_bus.wr_data[10:8]), $past(reg_bus.wr_data[2:0])})
    else $error("level register 2 did not take write");
  lv3_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h3 |=> level_timer_ch1 == $past(reg_bus.wr_data[2:0])
      && level_sync_serial_ch0 == $past(reg_bus.wr_data[10:8]))
    else $error("level register 3 did not take write");
  lv4_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h4 |=> level_i2c == $past(reg_bus.wr_data[2:0])
      && level_timer_ch2 == $past(reg_bus.wr_data[10:8]))
    else $error("level register 4 did not take write");
  lv5_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h5 |=> level_timer_ch3 == $past(reg_bus.wr_data[2:0])
      && level_timer_ch4 == $past(reg_bus.wr_data[10:8]))
    else $error("level register 5 did not take write");
  lv6_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h6 |=> level_sync_serial_ch1 == $past(reg_bus.wr_data[2:0])
      && level_lcd_driver == $past(reg_bus.wr_data[10:8]))
    else $error("level register 6 did not take write");
  lv7_update_a: assert property (
    wr_ok && reg_bus.wr_idx == 3'h7 |=> level_res_freq_conv == $past(reg_bus.wr_data[2:0])
      && level_mr_sensor == $past(reg_bus.wr_data[10:8]))
    else $error("level register 7 did not take write");
  reserved_zero_a: assert property (
    reg_bus.rd_en |=> (hrdata & ~{16'h0000, ILS_LV_MASK}) == 32'h0000_0000)
    else $error("reserved bits read non-zero");
  group_clear_a: assert property (
    hard_reset_group_zero |=> (lv_by_src == '0) and (!reg_bus.wr_en |=> lv_by_src == '0))
    else $error("reset group did not clear levels");
  level_hold_a: assert property (
    !reg_bus.wr_en && !hard_reset_group_zero |=> $stable(lv_by_src))
    else $error("level changed without a write");
  cpu_pick_a: assert property (
    irq_src == 16'h0000 |=> !cpu_irq_req ##0 cpu_irq_level == 3'h0)
    else $error("request raised with nothing pending");

  // Read path: stored word, forwarded write, or zero for a miss
  read_word_a: assert property (
    reg_bus.rd_en && reg_bus.rd_hit && !reg_bus.wr_en |=> hrdata[15:0] == $past(lv_words[reg_bus.rd_idx]))
    else $error("read data differs from stored word");
  read_fwd_a: assert property (
    reg_bus.rd_en && reg_bus.rd_hit && reg_bus.wr_en && reg_bus.wr_idx == reg_bus.rd_idx && !level_clear
      |=> hrdata == {16'h0000, $past(reg_bus.wr_data) & ILS_LV_MASK})
    else $error("read behind write missed new value");
  read_miss_a: assert property (
    reg_bus.rd_en && !reg_bus.rd_hit |=> hrdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // One check per source when it alone is pending
  for (genvar s = 0; s < ILS_NUM_SRC; s++) begin : g_alone
    src_alone_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq_src == (ILS_NUM_SRC'(1) << s) |=> cpu_irq_req && cpu_irq_src == ILS_SRC_W'(s)
        && cpu_irq_level == $past(lv_by_src[s]))
      else $error("lone request not offered with its level");
  end
endmodule : ils_top

// ===== bench/ils_periph_model.sv
// Peripheral side model: presents interrupt request levels to the block.
// Assumes the bench changes the pattern just after a core_clk rising edge.
`timescale 1ns/1ps
module ils_periph_model import ils_pkg::*; (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Pattern wanted by the bench
  input  wire logic [ILS_NUM_SRC-1:0] fire,
  // Request lines to the block
  output logic      [ILS_NUM_SRC-1:0] irq_src
);
  // ==========================================================
  // Request lines
  // Held as levels, one edge behind the wanted pattern
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_src <= '0;
    end else begin
      irq_src <= fire;
    end
  end
endmodule : ils_periph_model

// ===== bench/tb_top.sv
// Self-checking bench for the interrupt level setup block.
// Assumes a zero-wait AHB-Lite slave and the peripheral model beside it.
`timescale 1ns/1ps
module tb_top import ils_pkg::*; ();
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hard_reset_group_zero;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] fire;
  logic [15:0] irq_src;
  logic        cpu_irq_req;
  logic [2:0]  cpu_irq_level;
  logic [3:0]  cpu_irq_src;
  logic [2:0]  lv [16];
  logic [31:0] wv [8];
  logic [31:0] rd;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          num_checks = 0;

  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;

  // ==========================================================
  // Design and far side
  ils_top dut (.core_clk(core_clk), .rst_n(rst_n), .hard_reset_group_zero(hard_reset_group_zero),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_src(irq_src),
    .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level), .cpu_irq_src(cpu_irq_src));
  ils_periph_model peri (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .irq_src(irq_src));

  // ==========================================================
  // Helpers
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer, entered just after an edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask : xfer

  // Byte address of level register k
  function automatic logic [31:0] reg_addr(input int k);
    return {ILS_LV_INDEX[k], 2'h0};
  endfunction : reg_addr

  // Expected {request, level, source}: highest level, lowest index on tie
  function automatic logic [7:0] exp_sel(input logic [15:0] p);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (p[i] && (!r[7] || lv[i] > r[6:4])) r = {1'b1, lv[i], 4'(i)};
    end
    return r;
  endfunction : exp_sel

  // Write register k and track its two levels
  task automatic wr_reg(input int k, input logic [31:0] v);
    xfer(1'b1, reg_addr(k), v, rd);
    wv[k]     = v;
    lv[2*k]   = v[2:0];
    lv[2*k+1] = v[10:8];
  endtask : wr_reg

  // Drive a request pattern and check the CPU side three edges later
  task automatic sel_chk(input logic [15:0] p);
    fire <= p;
    repeat (3) @(posedge core_clk);
    chk({24'h0, cpu_irq_req, cpu_irq_level, cpu_irq_src}, {24'h0, exp_sel(p)});
  endtask : sel_chk

  // Verdict and end of run
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Watchdog against a hung bus
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    hard_reset_group_zero = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fire   = 16'h0;
    void'($urandom(32'h8929a325));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values of every register
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, reg_addr(k), 32'h0, rd);
      chk(rd, 32'h0);
    end
    // All ones, then random words; read back after an idle gap
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) wr_reg(k, (p == 0) ? 32'hffffffff : $urandom);
      repeat ($urandom_range(3, 20)) @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
        xfer(1'b0, reg_addr(k), 32'h0, rd);
        chk(rd, wv[k] & 32'h00000707);
      end
    end
    // Unmapped place: write ignored, read zero
    xfer(1'b1, 32'h0001023c, 32'hffffffff, rd);
    chk({31'h0, hresp}, 32'h0);
    xfer(1'b0, 32'h0001023c, 32'h0, rd);
    chk(rd, 32'h0);
    // Read right behind a write to the same register
    d = $urandom;
    hsel   <= 1'b1;
    haddr  <= reg_addr(3);
    hwrite <= 1'b1;
    htrans <= 2'h2;
    @(posedge core_clk);
    hwdata <= d;
    hwrite <= 1'b0;
    @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    @(posedge core_clk);
    chk(hrdata, d & 32'h00000707);
    lv[6] = d[2:0];
    lv[7] = d[10:8];
    // Each source alone shows its own field at the CPU side, then 12 random request patterns
    for (int i = 0; i < 16; i++) sel_chk(16'h1 << i);
    for (int i = 0; i < 12; i++) sel_chk(16'($urandom));
    // Tie of two equal levels, lower index wins
    wr_reg(0, 32'h00000505);
    sel_chk(16'h0003);
    // Reset group clears every level
    hard_reset_group_zero <= 1'b1;
    @(posedge core_clk);
    hard_reset_group_zero <= 1'b0;
    @(posedge core_clk);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, reg_addr(k), 32'h0, rd);
      chk(rd, 32'h0);
      lv[2*k]   = 3'h0;
      lv[2*k+1] = 3'h0;
    end
    sel_chk(16'h8000);
    give_verdict();
  end
endmodule : tb_top
